/* File: rtl/option_byte_decoder.sv */
// Option byte loader and decoder with APB view of the latched settings
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "option_byte_consts.svh"

module option_byte_decoder
#(
   parameter int CNT_W         = 20,
   parameter int SHORT_WAIT_CYC =
      (`SHORT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int XTAL_WAIT_CYC  =
      (`XTAL_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
)
(
   // Clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Flash array read port
   output logic                       flash_req,
   output logic [15:0]                flash_addr,
   input  wire logic [7:0]            flash_rdata,
   input  wire logic                  flash_ack,
   // Reset and power events
   input  wire logic                  sys_reset_req,
   input  wire logic                  stop_recovery,
   input  wire logic                  stop_mode,
   // Watchdog
   input  wire logic                  wdog_arm_instruction,
   input  wire logic                  wdog_timeout,
   output logic                       wdog_running,
   output logic                       wdog_timeout_irq,
   output logic                       wdog_timeout_rst,
   // Brown-out
   output logic                       brownout_enable,
   // Flash and debugger protection
   output logic                       code_readable,
   output logic                       dbg_full_access,
   output logic                       user_flash_write_en,
   output logic                       dbg_mass_erase_en,
   // Oscillator and CPU start
   output logic                       xtal_enable,
   output logic                       cpu_run
);
   import option_byte_pkg::*;

   generate
      if (CNT_W < 2 || CNT_W > 31)
      begin : bad_cnt_w
         $error("CNT_W out of range");
      end
      if (SHORT_WAIT_CYC < 1 || SHORT_WAIT_CYC >= (1 << CNT_W))
      begin : bad_short
         $error("SHORT_WAIT_CYC does not fit the counter");
      end
      if (XTAL_WAIT_CYC < 1 || XTAL_WAIT_CYC >= (1 << CNT_W))
      begin : bad_xtal
         $error("XTAL_WAIT_CYC does not fit the counter");
      end
   endgenerate

   // Reserved bits always read back as ones
   function automatic opt_byte_t view0(input opt_byte_t b);
      view0 = b | `OPT0_RSVD_ONES;
   endfunction : view0

   function automatic opt_byte_t view1(input opt_byte_t b);
      view1 = b | `OPT1_RSVD_ONES;
   endfunction : view1

   // Fetch engine

   logic       fetch_busy;
   logic       fetch_done;
   opt_byte_t  fetch_b0;
   opt_byte_t  fetch_b1;
   logic       reload_q;

   wire reload_req = sys_reset_req | stop_recovery;

   option_fetch u_fetch
   (
      .pclk         (pclk),
      .presetn      (presetn),
      .start        (reload_q),
      .busy_q       (fetch_busy),
      .done_q       (fetch_done),
      .flash_req_q  (flash_req),
      .flash_addr_q (flash_addr),
      .flash_rdata  (flash_rdata),
      .flash_ack    (flash_ack),
      .byte0_q      (fetch_b0),
      .byte1_q      (fetch_b1)
   );

   // Holding registers

   opt_byte_t  opt0_q;
   opt_byte_t  opt1_q;
   logic       loaded_q;

   // Only the end of a fetch (at reset, or after a reset or stop recovery request) updates them
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         opt0_q   <= `OPT_ERASED;
         opt1_q   <= `OPT_ERASED;
         loaded_q <= 1'b0;
      end
      else if (fetch_done)
      begin
         opt0_q   <= view0(fetch_b0);
         opt1_q   <= view1(fetch_b1);
         loaded_q <= 1'b1;
      end
   end

   // Fetched bytes as they will read once latched
   wire [7:0] fetch_v0 = view0(fetch_b0);
   wire [7:0] fetch_v1 = view1(fetch_b1);

   wire wdog_to_reset = opt0_q[`OPT0_WDOG_ACTION_BIT];
   wire wdog_ao_off   = opt0_q[`OPT0_WDOG_AO_BIT];
   wire bo_keep_on    = opt0_q[`OPT0_BO_KEEP_BIT];
   wire read_open     = opt0_q[`OPT0_READ_LOCK_BIT];
   wire write_open    = opt0_q[`OPT0_WRITE_LOCK_BIT];
   wire xtal_off      = opt1_q[`OPT1_XTAL_OFF_BIT];

   // Reset sequencing

   logic             cpu_run_q;
   logic             counting_q;
   logic [CNT_W-1:0] wait_q;
   logic             xtal_en_q;

   wire [CNT_W-1:0] wait_load = fetch_v1[`OPT1_XTAL_OFF_BIT]
                                ? CNT_W'(SHORT_WAIT_CYC)
                                : CNT_W'(XTAL_WAIT_CYC);
   wire wait_over = counting_q && (wait_q == CNT_W'(1));

   // A reload request drops the CPU until the new bytes are in and the start wait has run out
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reload_q   <= 1'b0;
         cpu_run_q  <= 1'b0;
         counting_q <= 1'b0;
         wait_q     <= '0;
      end
      else
      begin
         reload_q <= reload_req && !fetch_busy && !reload_q;
         if (reload_req)
            cpu_run_q <= 1'b0;
         else if (wait_over)
            cpu_run_q <= 1'b1;
         if (fetch_done)
         begin
            counting_q <= 1'b1;
            wait_q     <= wait_load;
         end
         else if (wait_over)
            counting_q <= 1'b0;
         else if (counting_q)
            wait_q <= wait_q - CNT_W'(1);
      end
   end

   // Crystal enable follows the bit; clock selection is left to software
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         xtal_en_q <= 1'b0;
      else if (fetch_done)
         xtal_en_q <= !fetch_v1[`OPT1_XTAL_OFF_BIT];
   end

   // Watchdog control

   logic wdog_run_q;
   logic wdog_irq_q;
   logic wdog_rst_q;

   wire wdog_arm   = wdog_arm_instruction && cpu_run_q;
   wire fetch_ao   = !fetch_v0[`OPT0_WDOG_AO_BIT];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wdog_run_q <= 1'b0;
      else if (fetch_done)
         // A reload ends an armed run; always-on restarts from the new byte
         wdog_run_q <= fetch_ao;
      else if (reload_req && wdog_ao_off)
         wdog_run_q <= 1'b0;
      else if (wdog_arm)
         wdog_run_q <= 1'b1;
   end

   // Timeout goes to interrupt or reset, never both
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wdog_irq_q <= 1'b0;
         wdog_rst_q <= 1'b0;
      end
      else
      begin
         wdog_irq_q <= wdog_timeout && wdog_run_q && !wdog_to_reset;
         wdog_rst_q <= wdog_timeout && wdog_run_q && wdog_to_reset;
      end
   end

   // Brown-out and protection outputs

   logic bo_stop_off_q;
   logic bo_en_q;
   logic readable_q;
   logic dbg_full_q;
   logic write_en_q;
   logic mass_erase_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bo_en_q      <= 1'b1;
         readable_q   <= 1'b0;
         dbg_full_q   <= 1'b0;
         write_en_q   <= 1'b0;
         mass_erase_q <= 1'b0;
      end
      else
      begin
         bo_en_q      <= bo_keep_on
                         || !(stop_mode && bo_stop_off_q);
         readable_q   <= read_open && loaded_q;
         dbg_full_q   <= read_open && loaded_q;
         write_en_q   <= write_open && loaded_q;
         mass_erase_q <= loaded_q;
      end
   end

   // APB slave

   logic [31:0] rdata_q;
   logic        ready_q;
   logic        err_q;

   wire [9:0] reg_idx   = paddr[11:2];
   wire       setup     = psel && !penable;
   wire       wr_commit = psel && penable && ready_q && pwrite;
   wire       hit_opt0  = (reg_idx == `IDX_OPT0);
   wire       hit_opt1  = (reg_idx == `IDX_OPT1);
   wire       hit_ctrl  = (reg_idx == `IDX_CTRL);
   wire       hit_stat  = (reg_idx == `IDX_STATUS);
   wire       mapped    = hit_opt0 || hit_opt1 || hit_ctrl || hit_stat;
   // Option bytes live in flash, so a bus write to them is an error
   wire       bad_acc   = !mapped || (pwrite && (hit_opt0 || hit_opt1));

   wire [31:0] status_word = {28'h0000000,
                              cpu_run_q,
                              xtal_en_q,
                              wdog_run_q,
                              loaded_q};

   wire [31:0] rd_mux = hit_opt0 ? {24'h000000, opt0_q}
                      : hit_opt1 ? {24'h000000, opt1_q}
                      : hit_ctrl ? {31'h00000000, bo_stop_off_q}
                      : hit_stat ? status_word
                      : 32'h00000000;

   // Answer is prepared in setup so the access phase never waits
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rdata_q <= 32'h00000000;
         ready_q <= 1'b0;
         err_q   <= 1'b0;
      end
      else
      begin
         ready_q <= setup;
         err_q   <= setup && bad_acc;
         if (setup && !pwrite)
            rdata_q <= rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         bo_stop_off_q <= `CTRL_RESET;
      else if (wr_commit && hit_ctrl)
         bo_stop_off_q <= pwdata[`CTRL_BO_STOP_OFF_BIT];
   end

   // Outputs straight from flops; latched values hold until reload
   assign prdata              = rdata_q;
   assign pready              = ready_q;
   assign pslverr             = err_q;
   assign wdog_running        = wdog_run_q;
   assign wdog_timeout_irq    = wdog_irq_q;
   assign wdog_timeout_rst    = wdog_rst_q;
   assign brownout_enable     = bo_en_q;
   assign code_readable       = readable_q;
   assign dbg_full_access     = dbg_full_q;
   assign user_flash_write_en = write_en_q;
   assign dbg_mass_erase_en   = mass_erase_q;
   assign xtal_enable         = xtal_en_q;
   assign cpu_run             = cpu_run_q;

endmodule : option_byte_decoder
`default_nettype wire

/* File: inc/option_byte_consts.svh */
// Constants for the option byte decoder: offsets, fields, resets, timing
`ifndef OPTION_BYTE_CONSTS_SVH
`define OPTION_BYTE_CONSTS_SVH

// Flash locations of the two user option bytes
`define FLASH_ADDR_OPT0      16'h0000
`define FLASH_ADDR_OPT1      16'h0001

// APB register indices; byte address is four times the index
`define IDX_OPT0             10'h000
`define IDX_OPT1             10'h001
`define IDX_CTRL             10'h002
`define IDX_STATUS           10'h003

// Option byte 0 fields
`define OPT0_WDOG_ACTION_BIT 7
`define OPT0_WDOG_AO_BIT     6
`define OPT0_BO_KEEP_BIT     3
`define OPT0_READ_LOCK_BIT   2
`define OPT0_WRITE_LOCK_BIT  0
`define OPT0_RSVD_ONES       8'h32

// Option byte 1 fields
`define OPT1_XTAL_OFF_BIT    4
`define OPT1_RSVD_ONES       8'hEF

// Erased flash reads as all ones
`define OPT_ERASED           8'hFF

// Control register fields
`define CTRL_BO_STOP_OFF_BIT 0
`define CTRL_RESET           1'h0

// Status register fields
`define STAT_LOADED_BIT      0
`define STAT_WDOG_RUN_BIT    1
`define STAT_XTAL_EN_BIT     2
`define STAT_CPU_RUN_BIT     3

// Reset sequence timing
`define CLK_PERIOD_NS        20
`define SHORT_RESET_NS       1000
`define XTAL_SETTLE_NS       5000000

`endif

/* File: inc/option_byte_pkg.sv */
// Types shared by the option byte decoder modules
package option_byte_pkg;

   typedef logic [7:0] opt_byte_t;

   typedef enum logic [2:0]
   {
      FETCH_IDLE = 3'b001,
      FETCH_LOW  = 3'b010,
      FETCH_HIGH = 3'b100
   } fetch_state_e;

endpackage : option_byte_pkg

/* File: rtl/option_fetch.sv */
// Reads the two option bytes from program flash on request
`timescale 1ns/1ns
`default_nettype none
`include "option_byte_consts.svh"

module option_fetch
(
   // Clock and reset
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   // Control
   input  wire logic                      start,
   output logic                           busy_q,
   output logic                           done_q,
   // Flash read port
   output logic                           flash_req_q,
   output logic [15:0]                    flash_addr_q,
   input  wire logic [7:0]                flash_rdata,
   input  wire logic                      flash_ack,
   // Fetched bytes
   output option_byte_pkg::opt_byte_t     byte0_q,
   output option_byte_pkg::opt_byte_t     byte1_q
);
   import option_byte_pkg::*;

   fetch_state_e state_q;
   fetch_state_e state_d;

   wire take_low  = (state_q == FETCH_LOW) && flash_ack;
   wire take_high = (state_q == FETCH_HIGH) && flash_ack;

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         FETCH_IDLE: if (start) state_d = FETCH_LOW;
         FETCH_LOW:  if (flash_ack) state_d = FETCH_HIGH;
         FETCH_HIGH: if (flash_ack) state_d = FETCH_IDLE;
         default:    state_d = FETCH_LOW;
      endcase
   end

   // Leaving reset starts a load at once
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q      <= FETCH_LOW;
         busy_q       <= 1'b1;
         done_q       <= 1'b0;
         flash_req_q  <= 1'b1;
         flash_addr_q <= `FLASH_ADDR_OPT0;
         byte0_q      <= `OPT_ERASED;
         byte1_q      <= `OPT_ERASED;
      end
      else
      begin
         state_q      <= state_d;
         busy_q       <= (state_d != FETCH_IDLE);
         done_q       <= take_high;
         flash_req_q  <= (state_d != FETCH_IDLE);
         flash_addr_q <= (state_d == FETCH_HIGH) ? `FLASH_ADDR_OPT1
                                                 : `FLASH_ADDR_OPT0;
         if (take_low)
            byte0_q <= flash_rdata;
         if (take_high)
            byte1_q <= flash_rdata;
      end
   end

endmodule : option_fetch
`default_nettype wire

/* File: verif/option_byte_decoder_props.sv */
// Port-level checks for the option byte decoder
`timescale 1ns/1ns
`default_nettype none
module option_byte_decoder_props
(
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   // Flash
   input wire logic        flash_req,
   input wire logic [15:0] flash_addr,
   input wire logic        flash_ack,
   // Events
   input wire logic        sys_reset_req,
   input wire logic        stop_mode,
   input wire logic        wdog_timeout,
   // Settings
   input wire logic        wdog_running,
   input wire logic        wdog_timeout_irq,
   input wire logic        wdog_timeout_rst,
   input wire logic        brownout_enable,
   input wire logic        code_readable,
   input wire logic        dbg_full_access,
   input wire logic        user_flash_write_en,
   input wire logic        xtal_enable,
   input wire logic        cpu_run
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_byte0_taken;
      flash_req && flash_ack && flash_addr == 16'h0000;
   endsequence
   sequence s_timeout_live;
      wdog_timeout && wdog_running;
   endsequence

   AST_PREADY_FIRST: assert property (s_setup |=> pready ##1 !pready)
      else $error("pready not a single first-access pulse");
   AST_OPT_WRITE_ERR: assert property
      (psel && penable && pready && pwrite && paddr[11:3] == 9'h000
       |-> pslverr) else $error("option byte write not refused");
   AST_BYTE_ORDER: assert property
      (s_byte0_taken |=> flash_req && flash_addr == 16'h0001)
      else $error("second flash byte not requested");
   AST_REQ_HOLD: assert property
      (flash_req && !flash_ack |=> flash_req && $stable(flash_addr))
      else $error("flash request dropped before ack");
   AST_TIMEOUT_ONE: assert property
      (s_timeout_live |=> wdog_timeout_irq != wdog_timeout_rst)
      else $error("timeout gave no single action");
   AST_TIMEOUT_IDLE: assert property
      (!(wdog_timeout && wdog_running)
       |=> !wdog_timeout_irq && !wdog_timeout_rst)
      else $error("timeout action without cause");
   AST_BO_AWAKE: assert property (!stop_mode |=> brownout_enable)
      else $error("brown-out off outside stop mode");
   AST_LOCK_PAIR: assert property
      (code_readable == dbg_full_access)
      else $error("read lock and debugger access disagree");
   AST_SETTINGS_HELD: assert property
      (cpu_run |-> $stable(code_readable) && $stable(xtal_enable)
       && $stable(user_flash_write_en))
      else $error("setting changed while running");
   AST_CPU_AFTER_FETCH: assert property (cpu_run |-> !flash_req)
      else $error("cpu running during fetch");
   AST_RELOAD: assert property
      (sys_reset_req && cpu_run |-> ##[1:6] flash_req && !cpu_run)
      else $error("reset request did not reload");
endmodule : option_byte_decoder_props

bind option_byte_decoder option_byte_decoder_props u_props
(
   .pclk                (pclk),
   .presetn             (presetn),
   .psel                (psel),
   .penable             (penable),
   .pwrite              (pwrite),
   .paddr               (paddr),
   .pready              (pready),
   .pslverr             (pslverr),
   .flash_req           (flash_req),
   .flash_addr          (flash_addr),
   .flash_ack           (flash_ack),
   .sys_reset_req       (sys_reset_req),
   .stop_mode           (stop_mode),
   .wdog_timeout        (wdog_timeout),
   .wdog_running        (wdog_running),
   .wdog_timeout_irq    (wdog_timeout_irq),
   .wdog_timeout_rst    (wdog_timeout_rst),
   .brownout_enable     (brownout_enable),
   .code_readable       (code_readable),
   .dbg_full_access     (dbg_full_access),
   .user_flash_write_en (user_flash_write_en),
   .xtal_enable         (xtal_enable),
   .cpu_run             (cpu_run)
);
`default_nettype wire

/* File: verif/flash_model.sv */
// Behavioural program flash holding the two option bytes
`timescale 1ns/1ns
`default_nettype none
module flash_model
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Read port
   input  wire logic        flash_req,
   input  wire logic [15:0] flash_addr,
   output logic [7:0]       flash_rdata,
   output logic             flash_ack,
   // Contents and pacing
   input  wire logic [7:0]  mem0,
   input  wire logic [7:0]  mem1,
   input  wire logic [2:0]  lag
);
   logic [2:0] wait_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wait_q      <= 3'h0;
         flash_ack   <= 1'b0;
         flash_rdata <= 8'hA5;
      end
      else if (flash_req && !flash_ack && wait_q >= lag)
      begin
         wait_q      <= 3'h0;
         flash_ack   <= 1'b1;
         flash_rdata <= flash_addr[0] ? mem1 : mem0;
      end
      else
      begin
         // Toggle so a stale byte never passes for a read
         wait_q      <= flash_req ? wait_q + 3'h1 : 3'h0;
         flash_ack   <= 1'b0;
         flash_rdata <= ~flash_rdata;
      end
   end
endmodule : flash_model
`default_nettype wire

/* File: verif/option_byte_decoder_tb.sv */
// Self-checking bench for the option byte decoder
`timescale 1ns/1ns
`default_nettype none
module option_byte_decoder_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        flash_req, flash_ack, sys_reset_req, stop_recovery;
   logic [15:0] flash_addr;
   logic [7:0]  flash_rdata, mem0, mem1;
   logic [2:0]  lag;
   logic        stop_mode, wdog_arm_instruction, wdog_timeout;
   logic        wdog_running, wdog_timeout_irq, wdog_timeout_rst;
   logic        brownout_enable, code_readable, dbg_full_access;
   logic        user_flash_write_en, dbg_mass_erase_en, xtal_enable, cpu_run;
   int          miscompares, checked, n_long, n_short;

   option_byte_decoder #(.SHORT_WAIT_CYC(3), .XTAL_WAIT_CYC(20))
      u_option_byte_decoder
   (
      .pclk                 (pclk),
      .presetn              (presetn),
      .psel                 (psel),
      .penable              (penable),
      .pwrite               (pwrite),
      .paddr                (paddr),
      .pwdata               (pwdata),
      .prdata               (prdata),
      .pready               (pready),
      .pslverr              (pslverr),
      .flash_req            (flash_req),
      .flash_addr           (flash_addr),
      .flash_rdata          (flash_rdata),
      .flash_ack            (flash_ack),
      .sys_reset_req        (sys_reset_req),
      .stop_recovery        (stop_recovery),
      .stop_mode            (stop_mode),
      .wdog_arm_instruction (wdog_arm_instruction),
      .wdog_timeout         (wdog_timeout),
      .wdog_running         (wdog_running),
      .wdog_timeout_irq     (wdog_timeout_irq),
      .wdog_timeout_rst     (wdog_timeout_rst),
      .brownout_enable      (brownout_enable),
      .code_readable        (code_readable),
      .dbg_full_access      (dbg_full_access),
      .user_flash_write_en  (user_flash_write_en),
      .dbg_mass_erase_en    (dbg_mass_erase_en),
      .xtal_enable          (xtal_enable),
      .cpu_run              (cpu_run)
   );

   flash_model u_flash_model
   (
      .pclk        (pclk),
      .presetn     (presetn),
      .flash_req   (flash_req),
      .flash_addr  (flash_addr),
      .flash_rdata (flash_rdata),
      .flash_ack   (flash_ack),
      .mem0        (mem0),
      .mem1        (mem1),
      .lag         (lag)
   );

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("FAIL %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk32

   task automatic chk1(input logic got, input logic exp);
      chk32({31'h0, got}, {31'h0, exp});
   endtask : chk1

   // Order: running, readable, full debug, write, mass erase, crystal
   task automatic chk_cfg(input logic [5:0] exp);
      chk32({26'h0, wdog_running, code_readable, dbg_full_access,
             user_flash_write_en, dbg_mass_erase_en, xtal_enable},
            {26'h0, exp});
   endtask : chk_cfg

   task automatic xfer(input logic w, input logic [9:0] idx,
                       input logic [31:0] d, input logic [31:0] exp,
                       input logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {idx, 2'b00};
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only pready or the watchdog may end this wait
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      chk1(pslverr, err);
      if (!w)
         chk32(prdata, exp);
   endtask : xfer

   task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 32'h0, exp, 1'b0);
   endtask : rd

   task automatic wr(input logic [9:0] idx, input logic [31:0] d,
                     input logic err);
      xfer(1'b1, idx, d, 32'h0, err);
   endtask : wr

   task automatic wait_run(output int n);
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (cpu_run !== 1'b1 && n < 2000);
      chk1(cpu_run, 1'b1);
   endtask : wait_run

   task automatic tmo(input logic irq, input logic rst);
      @(posedge pclk);
      wdog_timeout <= 1'b1;
      @(posedge pclk);
      wdog_timeout <= 1'b0;
      @(posedge pclk);
      chk1(wdog_timeout_irq, irq);
      chk1(wdog_timeout_rst, rst);
   endtask : tmo

   task automatic wrap_up;
      if (miscompares == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up

   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // Whole run is under two hundred cycles
   initial
   begin
      repeat (5000) @(posedge pclk);
      miscompares++;
      wrap_up();
   end

   initial
   begin
      miscompares = 0;
      checked = 0;
      {presetn, psel, penable, pwrite, sys_reset_req, stop_recovery} = '0;
      {stop_mode, wdog_arm_instruction, wdog_timeout} = '0;
      paddr = 12'h000;
      pwdata = 32'h0;
      mem0 = 8'h3A;
      mem1 = 8'hEF;
      lag = 3'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      wait_run(n_long);
      chk_cfg(6'b100011);
      rd(10'h000, 32'h0000003A);
      rd(10'h001, 32'h000000EF);
      rd(10'h003, 32'h0000000F);
      wr(10'h000, 32'h000000FF, 1'b1);
      wr(10'h006, 32'h00000000, 1'b1);
      tmo(1'b1, 1'b0);
      wr(10'h002, 32'h00000001, 1'b0);
      stop_mode <= 1'b1;
      repeat (3) @(posedge pclk);
      chk1(brownout_enable, 1'b1);
      mem0 <= 8'hF7;
      mem1 <= 8'hFF;
      repeat (3) @(posedge pclk);
      chk_cfg(6'b100011);
      sys_reset_req <= 1'b1;
      @(posedge pclk);
      sys_reset_req <= 1'b0;
      repeat (3) @(posedge pclk);
      chk1(cpu_run, 1'b0);
      wait_run(n_short);
      chk1(n_long > n_short + 8, 1'b1);
      chk_cfg(6'b011110);
      rd(10'h000, 32'h000000F7);
      wr(10'h002, 32'h00000001, 1'b0);
      repeat (2) @(posedge pclk);
      chk1(brownout_enable, 1'b0);
      stop_mode <= 1'b0;
      repeat (2) @(posedge pclk);
      chk1(brownout_enable, 1'b1);
      tmo(1'b0, 1'b0);
      wdog_arm_instruction <= 1'b1;
      @(posedge pclk);
      wdog_arm_instruction <= 1'b0;
      repeat (2) @(posedge pclk);
      chk1(wdog_running, 1'b1);
      tmo(1'b0, 1'b1);
      lag <= 3'h3;
      stop_recovery <= 1'b1;
      @(posedge pclk);
      stop_recovery <= 1'b0;
      repeat (3) @(posedge pclk);
      chk1(cpu_run, 1'b0);
      wait_run(n_short);
      chk1(wdog_running, 1'b0);
      rd(10'h001, 32'h000000FF);
      wrap_up();
   end
endmodule : option_byte_decoder_tb
`default_nettype wire
